// >>> src/asmc_regs.sv
// Amplifier switch and input-select configuration register bank.
// Assumes the serial control port has already turned host frames into
// single-cycle byte read and write strobes on mclk_in.
//
// Behaviour
// [R1] Register amp_switch_ctrl_a at 00H resets to 00H, bits 7 and 3 are zero, bits 6:4 drive ch1 switches a/b/c and bits 2:0 ch2 switches a/b/c.
// [R2] A stored 1 in a switch bit closes that switch and a 0 opens it.
// [R3] Register amp_switch_ctrl_b at 01H resets to 00H, bits 7 and 3 are zero, bits 6:4 drive ch3 switches a/b/c and bits 2:0 common switches two/one/zero.
// [R4] Register amp_input_select_a at 03H resets to 00H and holds four 2-bit select fields at 7:6, 5:4, 3:2 and 1:0.
// [R5] Each select field picks first pin on 00, second pin on 01, converter or reference pin on 10, and leaves the input open on 11.
// [R6] The host leaves unused configuration registers at their reset values.
// [R7] Analog reset from the pin or the internal reset control returns all three registers to their reset values.
// [R8] Fixed-zero bits ignore writes and always read back as zero.
`timescale 1ns/100ps
`default_nettype none
module asmc_regs (
  // Clock and resets
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic analog_reset_pin_n_in,
  input wire logic internal_reset_in,
  // Register access from the serial control port
  input wire logic [asmc_pkg::ASMC_ADDR_W-1:0] reg_addr_in,
  input wire logic [asmc_pkg::ASMC_DATA_W-1:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output logic [asmc_pkg::ASMC_DATA_W-1:0] reg_rdata_out,
  output logic reg_rvalid_out,
  // Channel one switches
  output logic ch1_switch_a_out,
  output logic ch1_switch_b_out,
  output logic ch1_switch_c_out,
  // Channel two switches
  output logic ch2_switch_a_out,
  output logic ch2_switch_b_out,
  output logic ch2_switch_c_out,
  // Channel three switches
  output logic ch3_switch_a_out,
  output logic ch3_switch_b_out,
  output logic ch3_switch_c_out,
  // Common switches
  output logic common_switch_two_out,
  output logic common_switch_one_out,
  output logic common_switch_zero_out,
  // Input mux controls, one-hot per field
  // Index 3 ch1 inverting, 2 ch1 non-inverting, 1 ch2 inverting, 0 ch2 non-inverting
  output logic [asmc_pkg::ASMC_NUM_SEL-1:0] sel_pin_first_out,
  output logic [asmc_pkg::ASMC_NUM_SEL-1:0] sel_pin_second_out,
  output logic [asmc_pkg::ASMC_NUM_SEL-1:0] sel_converter_out,
  output logic [asmc_pkg::ASMC_NUM_SEL-1:0] sel_open_out
);
  import asmc_pkg::*;

  logic [7:0] switch_ctrl_a_q;
  logic [7:0] switch_ctrl_b_q;
  logic [7:0] input_select_a_q;
  logic bank_rst;
  logic wr_a;
  logic wr_b;
  logic wr_sel;
  logic [7:0] rdata_d;

  asmc_sel_if sel_bus ();

  // Either analog reset source clears the bank like a system reset
  assign bank_rst = sys_rst_in | ~analog_reset_pin_n_in | internal_reset_in; // [R7]

  assign wr_a = reg_write_in && (reg_addr_in == ASMC_SWITCH_CTRL_A_OFS);
  assign wr_b = reg_write_in && (reg_addr_in == ASMC_SWITCH_CTRL_B_OFS);
  assign wr_sel = reg_write_in && (reg_addr_in == ASMC_INPUT_SELECT_A_OFS);

  // Switch register for channels one and two
  always_ff @(posedge mclk_in) begin
    if (bank_rst) begin
      switch_ctrl_a_q <= ASMC_SWITCH_CTRL_A_RST; // [R1] [R7]
    end else if (wr_a) begin
      switch_ctrl_a_q <= reg_wdata_in & ASMC_SWITCH_WMASK; // [R1] [R8]
    end
  end

  // Switch register for channel three and the common switches
  always_ff @(posedge mclk_in) begin
    if (bank_rst) begin
      switch_ctrl_b_q <= ASMC_SWITCH_CTRL_B_RST; // [R3] [R7]
    end else if (wr_b) begin
      switch_ctrl_b_q <= reg_wdata_in & ASMC_SWITCH_WMASK; // [R3] [R8]
    end
  end

  // Input select register
  always_ff @(posedge mclk_in) begin
    if (bank_rst) begin
      input_select_a_q <= ASMC_INPUT_SELECT_A_RST; // [R4] [R7]
    end else if (wr_sel) begin
      input_select_a_q <= reg_wdata_in & ASMC_SELECT_WMASK; // [R4]
    end
  end

  // Unmapped offsets read as zero; other bank registers live elsewhere
  always_comb begin
    unique case (reg_addr_in)
      ASMC_SWITCH_CTRL_A_OFS: rdata_d = switch_ctrl_a_q; // [R8]
      ASMC_SWITCH_CTRL_B_OFS: rdata_d = switch_ctrl_b_q; // [R8]
      ASMC_INPUT_SELECT_A_OFS: rdata_d = input_select_a_q;
      default: rdata_d = 8'h00;
    endcase
  end

  // Read answer one cycle after the strobe
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= 8'h00;
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rvalid_out <= reg_read_in;
      if (reg_read_in) begin
        reg_rdata_out <= rdata_d;
      end
    end
  end

  // Switch lines: high closes the switch; registered so they match the decode lag
  always_ff @(posedge mclk_in) begin
    if (bank_rst) begin
      ch1_switch_a_out <= 1'b0;
      ch1_switch_b_out <= 1'b0;
      ch1_switch_c_out <= 1'b0;
      ch2_switch_a_out <= 1'b0;
      ch2_switch_b_out <= 1'b0;
      ch2_switch_c_out <= 1'b0;
    end else begin
      ch1_switch_a_out <= switch_ctrl_a_q[ASMC_HI_SW_A_BIT]; // [R1] [R2]
      ch1_switch_b_out <= switch_ctrl_a_q[ASMC_HI_SW_B_BIT]; // [R1] [R2]
      ch1_switch_c_out <= switch_ctrl_a_q[ASMC_HI_SW_C_BIT]; // [R1] [R2]
      ch2_switch_a_out <= switch_ctrl_a_q[ASMC_LO_SW_A_BIT]; // [R1] [R2]
      ch2_switch_b_out <= switch_ctrl_a_q[ASMC_LO_SW_B_BIT]; // [R1] [R2]
      ch2_switch_c_out <= switch_ctrl_a_q[ASMC_LO_SW_C_BIT]; // [R1] [R2]
    end
  end

  always_ff @(posedge mclk_in) begin
    if (bank_rst) begin
      ch3_switch_a_out <= 1'b0;
      ch3_switch_b_out <= 1'b0;
      ch3_switch_c_out <= 1'b0;
      common_switch_two_out <= 1'b0;
      common_switch_one_out <= 1'b0;
      common_switch_zero_out <= 1'b0;
    end else begin
      ch3_switch_a_out <= switch_ctrl_b_q[ASMC_HI_SW_A_BIT]; // [R3] [R2]
      ch3_switch_b_out <= switch_ctrl_b_q[ASMC_HI_SW_B_BIT]; // [R3] [R2]
      ch3_switch_c_out <= switch_ctrl_b_q[ASMC_HI_SW_C_BIT]; // [R3] [R2]
      common_switch_two_out <= switch_ctrl_b_q[ASMC_LO_SW_A_BIT]; // [R3] [R2]
      common_switch_one_out <= switch_ctrl_b_q[ASMC_LO_SW_B_BIT]; // [R3] [R2]
      common_switch_zero_out <= switch_ctrl_b_q[ASMC_LO_SW_C_BIT]; // [R3] [R2]
    end
  end

  // Field slicing: index 3 is the topmost field
  assign sel_bus.sel[3] = asmc_sel_t'(input_select_a_q[ASMC_CH1_INV_LSB +: 2]); // [R4]
  assign sel_bus.sel[2] = asmc_sel_t'(input_select_a_q[ASMC_CH1_NONINV_LSB +: 2]); // [R4]
  assign sel_bus.sel[1] = asmc_sel_t'(input_select_a_q[ASMC_CH2_INV_LSB +: 2]); // [R4]
  assign sel_bus.sel[0] = asmc_sel_t'(input_select_a_q[ASMC_CH2_NONINV_LSB +: 2]); // [R4]

  asmc_sel_decode u_decode (
    .clk_in(mclk_in),
    .rst_in(bank_rst),
    .sel_if(sel_bus.decoder)
  );

  // Decoder lines are flops already
  assign sel_pin_first_out = sel_bus.pin_first;
  assign sel_pin_second_out = sel_bus.pin_second;
  assign sel_converter_out = sel_bus.converter;
  assign sel_open_out = sel_bus.open_input;
endmodule : asmc_regs
`default_nettype wire

// >>> src/asmc_pkg.sv
// Package for the amplifier switch and input-select register bank.
// Assumes a single host-port clock and a byte-wide register access port.
package asmc_pkg;
  localparam int unsigned ASMC_ADDR_W = 8;
  localparam int unsigned ASMC_DATA_W = 8;
  localparam int unsigned ASMC_NUM_SEL = 4;

  // Register offsets
  localparam logic [7:0] ASMC_SWITCH_CTRL_A_OFS = 8'h00;
  localparam logic [7:0] ASMC_SWITCH_CTRL_B_OFS = 8'h01;
  localparam logic [7:0] ASMC_INPUT_SELECT_A_OFS = 8'h03;

  // Reset values
  localparam logic [7:0] ASMC_SWITCH_CTRL_A_RST = 8'h00;
  localparam logic [7:0] ASMC_SWITCH_CTRL_B_RST = 8'h00;
  localparam logic [7:0] ASMC_INPUT_SELECT_A_RST = 8'h00;

  // Writable bits; bits 7 and 3 of the switch registers are fixed zero
  localparam logic [7:0] ASMC_SWITCH_WMASK = 8'h77;
  localparam logic [7:0] ASMC_SELECT_WMASK = 8'hFF;

  // Switch field positions (a, b, c of the upper and lower group)
  localparam int unsigned ASMC_HI_SW_A_BIT = 6;
  localparam int unsigned ASMC_HI_SW_B_BIT = 5;
  localparam int unsigned ASMC_HI_SW_C_BIT = 4;
  localparam int unsigned ASMC_LO_SW_A_BIT = 2;
  localparam int unsigned ASMC_LO_SW_B_BIT = 1;
  localparam int unsigned ASMC_LO_SW_C_BIT = 0;

  // Select field positions (low bit of each 2-bit field)
  localparam int unsigned ASMC_CH1_INV_LSB = 6;
  localparam int unsigned ASMC_CH1_NONINV_LSB = 4;
  localparam int unsigned ASMC_CH2_INV_LSB = 2;
  localparam int unsigned ASMC_CH2_NONINV_LSB = 0;

  // Select field encoding
  typedef enum logic [1:0] {
    ASMC_SEL_PIN_FIRST = 2'b00,
    ASMC_SEL_PIN_SECOND = 2'b01,
    ASMC_SEL_CONVERTER = 2'b10,
    ASMC_SEL_OPEN = 2'b11
  } asmc_sel_t;
endpackage : asmc_pkg

// >>> src/asmc_sel_if.sv
// Carrier between the register bank and the select decoder.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface asmc_sel_if;
  import asmc_pkg::*;
  asmc_sel_t sel [ASMC_NUM_SEL];
  logic [ASMC_NUM_SEL-1:0] pin_first;
  logic [ASMC_NUM_SEL-1:0] pin_second;
  logic [ASMC_NUM_SEL-1:0] converter;
  logic [ASMC_NUM_SEL-1:0] open_input;

  modport bank (output sel, input pin_first, pin_second, converter, open_input);
  modport decoder (input sel, output pin_first, pin_second, converter, open_input);
endinterface : asmc_sel_if
`default_nettype wire

// >>> src/asmc_sel_decode.sv
// Registered one-hot decode of the four 2-bit input select fields.
// Assumes a synchronous active-high reset shared with the register bank.
`timescale 1ns/100ps
`default_nettype none
module asmc_sel_decode (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Select fields in, decoded lines out
  asmc_sel_if.decoder sel_if
);
  import asmc_pkg::*;

  // One flop per line per field, so the analog controls never glitch
  for (genvar i = 0; i < ASMC_NUM_SEL; i++) begin : g_field
    always_ff @(posedge clk_in) begin
      if (rst_in) begin
        // Reset value 00 of the field selects the first pin
        sel_if.pin_first[i] <= 1'b1;
        sel_if.pin_second[i] <= 1'b0;
        sel_if.converter[i] <= 1'b0;
        sel_if.open_input[i] <= 1'b0;
      end else begin
        sel_if.pin_first[i] <= (sel_if.sel[i] == ASMC_SEL_PIN_FIRST); // [R5]
        sel_if.pin_second[i] <= (sel_if.sel[i] == ASMC_SEL_PIN_SECOND); // [R5]
        sel_if.converter[i] <= (sel_if.sel[i] == ASMC_SEL_CONVERTER); // [R5]
        sel_if.open_input[i] <= (sel_if.sel[i] == ASMC_SEL_OPEN); // [R5]
      end
    end
  end
endmodule : asmc_sel_decode
`default_nettype wire

// >>> verification/asmc_regs_monitor.sv
// Checker for the switch and input-select register bank.
// Assumes one clock and a strobe port answered one cycle later.
`timescale 1ns/100ps
`default_nettype none
module asmc_regs_monitor (
  // Clock and resets
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic analog_reset_pin_n_in,
  input wire logic internal_reset_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic reg_rvalid_out,
  // Watched controls
  input wire logic ch1_switch_a_out,
  input wire logic ch2_switch_c_out,
  input wire logic ch3_switch_a_out,
  input wire logic common_switch_zero_out,
  input wire logic [3:0] sel_pin_first_out,
  input wire logic [3:0] sel_open_out
);
  logic ok;
  assign ok = analog_reset_pin_n_in & ~internal_reset_in;
  default clocking @(posedge mclk_in);
  endclocking
  default disable iff (sys_rst_in);
  chk_read_answer: assert property (reg_read_in |=> reg_rvalid_out)
    else $error("read not answered");
  chk_rvalid_only: assert property (!reg_read_in |=> !reg_rvalid_out)
    else $error("stray read answer");
  chk_zero_bits: assert property (reg_rvalid_out && $past(reg_addr_in) != 8'h03
    |-> reg_rdata_out[7] == 1'b0 && reg_rdata_out[3] == 1'b0) else $error("fixed bit set");
  chk_ch1_switch: assert property ((reg_write_in && reg_addr_in == 8'h00 && ok) ##1 ok
    |=> ch1_switch_a_out == $past(reg_wdata_in[6], 2)) else $error("ch1 switch wrong");
  chk_ch2_switch: assert property ((reg_write_in && reg_addr_in == 8'h00 && ok) ##1 ok
    |=> ch2_switch_c_out == $past(reg_wdata_in[0], 2)) else $error("ch2 switch wrong");
  chk_ch3_common: assert property ((reg_write_in && reg_addr_in == 8'h01 && ok) ##1 ok
    |=> {ch3_switch_a_out, common_switch_zero_out} == {$past(reg_wdata_in[6], 2),
    $past(reg_wdata_in[0], 2)}) else $error("ch3 or common switch wrong");
  chk_sel_decode: assert property ((reg_write_in && reg_addr_in == 8'h03 && ok) ##1 ok
    |=> sel_open_out[3] == &$past(reg_wdata_in[7:6], 2) && sel_pin_first_out[0] ==
    ~|$past(reg_wdata_in[1:0], 2)) else $error("select decode wrong");
  chk_analog_reset: assert property (!ok |=> !ch1_switch_a_out && !ch3_switch_a_out
    && sel_pin_first_out == 4'hF && sel_open_out == 4'h0) else $error("reset ignored");
endmodule : asmc_regs_monitor
bind asmc_regs asmc_regs_monitor i_asmc_regs_monitor (.mclk_in, .sys_rst_in,
  .analog_reset_pin_n_in, .internal_reset_in, .reg_addr_in, .reg_wdata_in, .reg_write_in,
  .reg_read_in, .reg_rdata_out, .reg_rvalid_out, .ch1_switch_a_out, .ch2_switch_c_out,
  .ch3_switch_a_out, .common_switch_zero_out, .sel_pin_first_out, .sel_open_out);
`default_nettype wire

// >>> verification/asmc_regs_host.sv
// Host model driving the byte strobe port.
// Assumes a strobe set after one edge is taken at the next.
`timescale 1ns/100ps
`default_nettype none
module asmc_regs_host (
  // Clock
  input wire logic mclk_in,
  // Register port
  output logic [7:0] reg_addr_out = 8'h00,
  output logic [7:0] reg_wdata_out = 8'h00,
  output logic reg_write_out = 1'b0,
  output logic reg_read_out = 1'b0
);
  // Host drives one strobe cycle per call, at whatever address it is given
  task automatic acc(input logic w, r, input logic [7:0] a, d);
    @(posedge mclk_in);
    reg_write_out <= w;
    reg_read_out <= r;
    reg_addr_out <= a;
    reg_wdata_out <= d;
  endtask : acc
  // Released lines toggle so stale values never pass
  task automatic idle();
    acc(1'b0, 1'b0, ~reg_addr_out, ~reg_wdata_out);
  endtask : idle
endmodule : asmc_regs_host
`default_nettype wire

// >>> verification/asmc_regs_test.sv
// Self-checking bench for the switch and input-select register bank.
// Assumes the host model drives the port and the bench drives resets.
`timescale 1ns/100ps
`default_nettype none
module asmc_regs_test;
  logic clk = 1'b0, rst = 1'b1, pin_n = 1'b1, irst = 1'b0, wr, rd, rv;
  logic [7:0] ad, wd, rdat, sa = 8'h00, sb = 8'h00, ss = 8'h00;
  logic [7:0] tbl [4] = '{8'hE4, 8'h39, 8'h4E, 8'h93};
  wire logic [11:0] sw;
  logic [11:0] q[$];
  logic [3:0] pf, ps, pc, po;
  int error_cnt = 0;
  int samples_checked = 0;
  always #20 clk = ~clk;
  asmc_regs_host i_asmc_regs_host (.mclk_in(clk), .reg_addr_out(ad), .reg_wdata_out(wd),
    .reg_write_out(wr), .reg_read_out(rd));
  asmc_regs i_asmc_regs (.mclk_in(clk), .sys_rst_in(rst), .analog_reset_pin_n_in(pin_n),
    .internal_reset_in(irst), .reg_addr_in(ad), .reg_wdata_in(wd), .reg_write_in(wr),
    .reg_read_in(rd), .reg_rdata_out(rdat), .reg_rvalid_out(rv), .ch1_switch_a_out(sw[11]),
    .ch1_switch_b_out(sw[10]), .ch1_switch_c_out(sw[9]), .ch2_switch_a_out(sw[8]),
    .ch2_switch_b_out(sw[7]), .ch2_switch_c_out(sw[6]), .ch3_switch_a_out(sw[5]),
    .ch3_switch_b_out(sw[4]), .ch3_switch_c_out(sw[3]), .common_switch_two_out(sw[2]),
    .common_switch_one_out(sw[1]), .common_switch_zero_out(sw[0]), .sel_pin_first_out(pf),
    .sel_pin_second_out(ps), .sel_converter_out(pc), .sel_open_out(po));
  task automatic cmp(input logic [11:0] got, exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp
  task automatic wr_reg(input logic [7:0] a, d);
    i_asmc_regs_host.acc(1'b1, 1'b0, a, d);
    if (a == 8'h00) sa = d & 8'h77;
    if (a == 8'h01) sb = d & 8'h77;
    if (a == 8'h03) ss = d;
  endtask : wr_reg
  task automatic rd_exp(input logic [7:0] a, e);
    q.push_back(e);
    i_asmc_regs_host.acc(1'b0, 1'b1, a, 8'h00);
  endtask : rd_exp
  // Three quiet cycles cover strobe, register and output lag
  task automatic settle();
    logic [1:0] f;
    repeat (3) i_asmc_regs_host.idle();
    @(negedge clk);
    cmp(sw, {sa[6:4], sa[2:0], sb[6:4], sb[2:0]}, "switch");
    for (int i = 0; i < 4; i++) begin
      f = ss[2*i +: 2];
      cmp({pf[i], ps[i], pc[i], po[i]}, {f == 0, f == 1, f == 2, f == 3}, "select");
    end
  endtask : settle
  task automatic finish_test();
    $display("checked %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test
  always @(negedge clk) begin
    if (rv === 1'b1) begin
      if (q.size() == 0) q.push_back(12'hFFF);
      cmp(rdat, q.pop_front(), "read");
    end
  end
  initial begin
    void'($urandom(32'hE8B9));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 4; a++) rd_exp(8'(a), 8'h00);
    settle();
    $display("test reset_values done");
    for (int n = 0; n < 6; n++) begin
      wr_reg(8'h00, n == 0 ? 8'hFF : 8'($urandom));
      wr_reg(8'h01, n == 0 ? 8'hFF : 8'($urandom));
      wr_reg(8'h03, n < 4 ? tbl[n] : 8'($urandom));
      rd_exp(8'h00, sa);
      rd_exp(8'h01, sb);
      rd_exp(8'h03, ss);
      settle();
    end
    $display("test write_read done");
    wr_reg(8'h02, 8'($urandom));
    rd_exp(8'h02, 8'h00);
    q.push_back(sb);
    i_asmc_regs_host.acc(1'b1, 1'b1, 8'h01, 8'h5A);
    sb = 8'h52;
    settle();
    $display("test unmapped_overlap done");
    for (int k = 0; k < 2; k++) begin
      wr_reg(8'h00, 8'h77);
      wr_reg(8'h01, 8'h77);
      wr_reg(8'h03, 8'hFF);
      settle();
      @(posedge clk);
      pin_n <= k[0];
      irst <= k[0];
      i_asmc_regs_host.acc(1'b1, 1'b0, 8'h00, 8'hFF);
      rd_exp(8'h00, 8'h00);
      i_asmc_regs_host.idle();
      @(posedge clk);
      pin_n <= 1'b1;
      irst <= 1'b0;
      {sa, sb, ss} = 24'h000000;
      settle();
    end
    $display("test analog_reset done");
    cmp(q.size(), 12'h000, "queue");
    finish_test();
  end
  initial begin
    #80000;
    error_cnt++;
    finish_test();
  end
endmodule : asmc_regs_test
`default_nettype wire
